// [design/fsb_arb_pkg.sv]
// Package: constants and carriers for the bus arbitration control block
package fsb_arb_pkg;
  localparam int MON_W = 6;
  localparam int PROBE_READY_BIT = 4;
  localparam int PROBE_REQ_BIT = 5;
  localparam int SEL_W = 3;
  localparam logic [2:0] FREQ_SEL_RST = 3'h0;
  localparam logic [1:0] AGENT_ID_RST = 2'h0;
  localparam logic [1:0] AGENT_ID_ZERO = 2'h0;
  // ID taken when bus request is seen high at the latch
  localparam logic [1:0] AGENT_ID_OTHER = 2'h3;
  // Register offsets
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_STAT = 4'h1;
  localparam logic [3:0] REG_IRQ = 4'h2;
  localparam logic [3:0] REG_MASK = 4'h3;
  localparam logic [3:0] REG_MON = 4'h4;
  // Control fields
  localparam int CTRL_REQ = 0;
  localparam int CTRL_ERR = 1;
  localparam int CTRL_FULL = 2;
  localparam int CTRL_READY = 3;
  localparam int CTRL_LOCK = 4;
  localparam int CTRL_SEL = 8;
  localparam int CTRL_MON = 16;
  localparam logic [31:0] CTRL_RST = 32'h0;
  // Event fields
  localparam int EV_INIT = 0;
  localparam int EV_PRI = 1;
  localparam int EV_STALL = 2;
  localparam int EV_PROBE = 3;
  localparam int EV_W = 4;
  localparam logic [3:0] EV_RST = 4'h0;

  typedef enum logic [3:0] {
    ARB_IDLE = 4'h1,
    ARB_REQ = 4'h2,
    ARB_OWN = 4'h4,
    ARB_HOLD = 4'h8
  } arb_state_e;

  typedef struct packed {
    logic bus_init_n;
    logic block_next_req_n;
    logic priority_req_n;
    logic system_bus_req0_n;
    logic probe_request_n;
  } bus_in_s;

  typedef struct packed {
    logic drv_en;
    logic obs_en;
    logic [1:0] agent_id;
  } cfg_s;
endpackage : fsb_arb_pkg

// [design/fsb_arbitration_control.sv]
// Arbitration, stall and bus-init control of one front_side_bus agent
// Operation
// - Drive bus init on fatal condition
// - Bus init resets lock and arbiter
// - Bus init keeps in_order_queue tracking
// - Re-arbitrate after bus init, finish pending
// - Assert block-next-request when unable to accept
// - No new transactions during stall
// - Drive five of the six breakpoint monitor lines
// - Monitor line 4 is probe ready
// - Monitor line 5 is probe request input
// - Priority request stops new non-locked requests
// - Request bus on agent bus request
// - Sample bus request at reset for ID
// - Drive three-bit clock frequency select
//
// The strobed register port and the register addresses are this design's own decisions.
module fsb_arbitration_control #(
  parameter int MON_W = fsb_arb_pkg::MON_W,
  parameter int SEL_W = fsb_arb_pkg::SEL_W
) (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic clk_en_i,
  input wire logic cfg_drv_en_i,
  input wire logic cfg_obs_en_i,
  input wire fsb_arb_pkg::bus_in_s bus_i,
  input wire logic pending_i,
  input wire logic [3:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [31:0] rdata_o,
  output logic irq_o,
  output logic agent_bus_req_n_o,
  output logic agent_bus_req_oe_o,
  output logic bus_init_n_o,
  output logic bus_init_oe_o,
  output logic block_next_req_n_o,
  output logic block_next_req_oe_o,
  output logic [MON_W-1:0] brkpt_mon_n_o,
  output logic [MON_W-1:0] brkpt_mon_oe_o,
  output logic [SEL_W-1:0] clk_freq_select_o,
  output logic issue_o,
  output logic [1:0] agent_id_o
);
  logic [31:0] ctrl;
  logic [fsb_arb_pkg::EV_W-1:0] irq_stat;
  logic [fsb_arb_pkg::EV_W-1:0] irq_mask;
  logic [fsb_arb_pkg::EV_W-1:0] ev;
  logic [MON_W-1:0] mon_val;
  fsb_arb_pkg::cfg_s cfg;
  fsb_arb_pkg::arb_state_e state;
  fsb_arb_pkg::arb_state_e next_state;
  logic rst_d;
  logic init_seen;
  logic lock_active;
  logic stall_seen;
  logic pri_seen;
  logic pri_d;
  logic stall_d;
  logic probe_d;
  logic can_issue;
  logic wr_ctrl;

  assign init_seen = cfg.obs_en && !bus_i.bus_init_n;
  assign stall_seen = !bus_i.block_next_req_n;
  assign pri_seen = !bus_i.priority_req_n;
  assign wr_ctrl = wr_i && addr_i == fsb_arb_pkg::REG_CTRL;
  // stall blocks issue; priority blocks unless locked
  assign can_issue = state == fsb_arb_pkg::ARB_OWN && !stall_seen &&
                     (!pri_seen || lock_active);

  // options taken one cycle after reset release
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      rst_d <= 1'b1;
    end else if (clk_en_i) begin
      rst_d <= 1'b0;
    end
  end

  // bus request sampled low gives agent ID 0
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      cfg <= '{1'b0, 1'b0, fsb_arb_pkg::AGENT_ID_RST};
    end else if (clk_en_i && rst_d) begin
      cfg.drv_en <= cfg_drv_en_i;
      cfg.obs_en <= cfg_obs_en_i;
      cfg.agent_id <= bus_i.system_bus_req0_n ? fsb_arb_pkg::AGENT_ID_OTHER
                      : fsb_arb_pkg::AGENT_ID_ZERO;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      ctrl <= fsb_arb_pkg::CTRL_RST;
    end else if (clk_en_i && wr_ctrl) begin
      ctrl <= wdata_i;
    end
  end

  // bus init clears the lock tracker
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      lock_active <= 1'b0;
    end else if (clk_en_i) begin
      if (init_seen) begin
        lock_active <= 1'b0;
      end else begin
        lock_active <= ctrl[fsb_arb_pkg::CTRL_LOCK] &&
                       state == fsb_arb_pkg::ARB_OWN;
      end
    end
  end

  // pending work keeps requesting after bus init
  always_comb begin
    next_state = state;
    case (state)
      fsb_arb_pkg::ARB_IDLE: begin
        if (ctrl[fsb_arb_pkg::CTRL_REQ] || pending_i) begin
          next_state = fsb_arb_pkg::ARB_REQ;
        end
      end
      fsb_arb_pkg::ARB_REQ: begin
        if (!pri_seen) begin
          next_state = fsb_arb_pkg::ARB_OWN;
        end
      end
      fsb_arb_pkg::ARB_OWN: begin
        if (pri_seen && !lock_active) begin
          next_state = fsb_arb_pkg::ARB_HOLD;
        end else if (!ctrl[fsb_arb_pkg::CTRL_REQ] && !pending_i) begin
          next_state = fsb_arb_pkg::ARB_IDLE;
        end
      end
      fsb_arb_pkg::ARB_HOLD: begin
        if (!pri_seen) begin
          next_state = fsb_arb_pkg::ARB_REQ;
        end
      end
      default: next_state = fsb_arb_pkg::ARB_IDLE;
    endcase
  end

  // bus init resets arbiter; queue state is external, untouched
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      state <= fsb_arb_pkg::ARB_IDLE;
    end else if (clk_en_i) begin
      state <= init_seen ? fsb_arb_pkg::ARB_IDLE : next_state;
    end
  end

  // request bus while requesting or owning
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      agent_bus_req_n_o <= 1'b1;
      agent_bus_req_oe_o <= 1'b0;
      issue_o <= 1'b0;
    end else if (clk_en_i) begin
      agent_bus_req_n_o <= !(next_state == fsb_arb_pkg::ARB_REQ ||
                             next_state == fsb_arb_pkg::ARB_OWN) ||
                           init_seen;
      agent_bus_req_oe_o <= 1'b1;
      issue_o <= can_issue && !init_seen;
    end
  end

  // drive bus init only with driver enabled
  // drive stall while unable to accept
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      bus_init_n_o <= 1'b1;
      bus_init_oe_o <= 1'b0;
      block_next_req_n_o <= 1'b1;
      block_next_req_oe_o <= 1'b0;
    end else if (clk_en_i) begin
      bus_init_n_o <= !(cfg.drv_en && ctrl[fsb_arb_pkg::CTRL_ERR]);
      bus_init_oe_o <= cfg.drv_en && ctrl[fsb_arb_pkg::CTRL_ERR];
      block_next_req_n_o <= !ctrl[fsb_arb_pkg::CTRL_FULL];
      block_next_req_oe_o <= ctrl[fsb_arb_pkg::CTRL_FULL];
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      clk_freq_select_o <= fsb_arb_pkg::FREQ_SEL_RST;
      agent_id_o <= fsb_arb_pkg::AGENT_ID_RST;
    end else if (clk_en_i) begin
      clk_freq_select_o <= ctrl[fsb_arb_pkg::CTRL_SEL +: SEL_W];
      agent_id_o <= cfg.agent_id;
    end
  end

  // monitor lines driven from software; line 4 probe ready
  always_comb begin
    mon_val = ctrl[fsb_arb_pkg::CTRL_MON +: MON_W];
    mon_val[fsb_arb_pkg::PROBE_READY_BIT] = ctrl[fsb_arb_pkg::CTRL_READY];
  end

  // line 5 never driven, it is the probe request input
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      brkpt_mon_n_o <= '1;
      brkpt_mon_oe_o <= '0;
    end else if (clk_en_i) begin
      brkpt_mon_n_o <= ~mon_val | (MON_W'(1) << fsb_arb_pkg::PROBE_REQ_BIT);
      brkpt_mon_oe_o <= ~(MON_W'(1) << fsb_arb_pkg::PROBE_REQ_BIT);
    end
  end

  // Edge detect so a held line raises one event, not a flood
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      pri_d <= 1'b0;
      stall_d <= 1'b0;
      probe_d <= 1'b0;
    end else if (clk_en_i) begin
      pri_d <= pri_seen;
      stall_d <= stall_seen;
      probe_d <= !bus_i.probe_request_n;
    end
  end

  always_comb begin
    ev = fsb_arb_pkg::EV_RST;
    ev[fsb_arb_pkg::EV_INIT] = init_seen;
    ev[fsb_arb_pkg::EV_PRI] = pri_seen && !pri_d;
    ev[fsb_arb_pkg::EV_STALL] = stall_seen && !stall_d;
    ev[fsb_arb_pkg::EV_PROBE] = !bus_i.probe_request_n && !probe_d;
  end

  // Set wins over a write-one clear in the same cycle
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      irq_stat <= fsb_arb_pkg::EV_RST;
      irq_mask <= fsb_arb_pkg::EV_RST;
      irq_o <= 1'b0;
    end else if (clk_en_i) begin
      if (wr_i && addr_i == fsb_arb_pkg::REG_IRQ) begin
        irq_stat <= (irq_stat & ~wdata_i[fsb_arb_pkg::EV_W-1:0]) | ev;
      end else begin
        irq_stat <= irq_stat | ev;
      end
      if (wr_i && addr_i == fsb_arb_pkg::REG_MASK) begin
        irq_mask <= wdata_i[fsb_arb_pkg::EV_W-1:0];
      end
      irq_o <= |(irq_stat & irq_mask);
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      rdata_o <= 32'h0;
    end else if (clk_en_i) begin
      rdata_o <= 32'h0;
      if (rd_i) begin
        case (addr_i)
          fsb_arb_pkg::REG_CTRL: rdata_o <= ctrl;
          fsb_arb_pkg::REG_STAT: rdata_o <= {20'h0, cfg.agent_id,
            cfg.obs_en, cfg.drv_en, state, lock_active, issue_o,
            pri_seen, stall_seen};
          fsb_arb_pkg::REG_IRQ: rdata_o <= {28'h0, irq_stat};
          fsb_arb_pkg::REG_MASK: rdata_o <= {28'h0, irq_mask};
          fsb_arb_pkg::REG_MON: rdata_o <= {26'h0, ~brkpt_mon_n_o};
          default: rdata_o <= 32'h0;
        endcase
      end
    end
  end

  a_stall_no_issue: assert property (@(posedge sys_clk_i)
    disable iff (rst_i) clk_en_i && stall_seen |=> !issue_o)
    else $error("issue during stall");
  a_pri_no_issue: assert property (@(posedge sys_clk_i)
    disable iff (rst_i) clk_en_i && pri_seen && !lock_active
    |=> !issue_o)
    else $error("issue during priority request");
  // bus init returns arbiter to idle
  a_init_idle: assert property (@(posedge sys_clk_i)
    disable iff (rst_i) clk_en_i && init_seen
    |=> state == fsb_arb_pkg::ARB_IDLE && !lock_active)
    else $error("bus init did not reset arbiter");
  a_init_event: assert property (@(posedge sys_clk_i)
    disable iff (rst_i) clk_en_i && init_seen
    |=> irq_stat[fsb_arb_pkg::EV_INIT])
    else $error("bus init not flagged");
  // bus init driven only when enabled
  a_init_drive: assert property (@(posedge sys_clk_i)
    disable iff (rst_i) !bus_init_n_o |-> cfg.drv_en)
    else $error("bus init driven while disabled");
  a_probe_in: assert property (@(posedge sys_clk_i)
    disable iff (rst_i) !brkpt_mon_oe_o[fsb_arb_pkg::PROBE_REQ_BIT])
    else $error("probe request line driven");
  // probe ready follows control bit
  // Old control value: a write lands one cycle before the line moves
  a_probe_ready: assert property (@(posedge sys_clk_i)
    disable iff (rst_i) clk_en_i
    |=> brkpt_mon_n_o[fsb_arb_pkg::PROBE_READY_BIT]
        == !$past(ctrl[fsb_arb_pkg::CTRL_READY]))
    else $error("probe ready mismatch");
  // low monitor lines follow control field
  a_mon_low: assert property (@(posedge sys_clk_i)
    disable iff (rst_i) clk_en_i
    |=> brkpt_mon_n_o[fsb_arb_pkg::PROBE_READY_BIT-1:0]
        == ~$past(ctrl[fsb_arb_pkg::CTRL_MON +:
                       fsb_arb_pkg::PROBE_READY_BIT]))
    else $error("monitor lines mismatch");
  a_stall_drive: assert property (@(posedge sys_clk_i)
    disable iff (rst_i) clk_en_i && ctrl[fsb_arb_pkg::CTRL_FULL]
    |=> !block_next_req_n_o)
    else $error("stall not driven");
  a_cfg_hold: assert property (@(posedge sys_clk_i)
    disable iff (rst_i) !rst_d && !$past(rst_d) |-> $stable(cfg))
    else $error("options changed after reset");
  // ID zero exactly when bus request was low
  a_id_latch: assert property (@(posedge sys_clk_i)
    disable iff (rst_i) clk_en_i && !rst_i && rst_d
    |=> (cfg.agent_id == fsb_arb_pkg::AGENT_ID_ZERO)
        == !$past(bus_i.system_bus_req0_n))
    else $error("agent ID not latched from bus request");
  // request drives line low next cycle
  a_req_line: assert property (@(posedge sys_clk_i)
    disable iff (rst_i) clk_en_i && state == fsb_arb_pkg::ARB_OWN &&
    next_state == fsb_arb_pkg::ARB_OWN && !init_seen
    |=> !agent_bus_req_n_o)
    else $error("bus request not driven");
  a_freq_sel: assert property (@(posedge sys_clk_i)
    disable iff (rst_i) clk_en_i |=>
    clk_freq_select_o == $past(ctrl[fsb_arb_pkg::CTRL_SEL +: SEL_W]))
    else $error("frequency select mismatch");

  c_own: cover property (@(posedge sys_clk_i) state == fsb_arb_pkg::ARB_OWN);
  c_hold: cover property (@(posedge sys_clk_i)
    state == fsb_arb_pkg::ARB_HOLD);
  c_init: cover property (@(posedge sys_clk_i) init_seen && !rst_i);
  c_irq: cover property (@(posedge sys_clk_i) irq_o);
  c_probe: cover property (@(posedge sys_clk_i) ev[fsb_arb_pkg::EV_PROBE]);
endmodule : fsb_arbitration_control

// [verif/fsb_bus_partner.sv]
// Far-side model: other agents, priority agent, chipset and debug tool
module fsb_bus_partner #(
  parameter int PRI_LEN = 6
) (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic strap_id0_i,
  input wire logic init_i,
  input wire logic stall_i,
  input wire logic pri_go_i,
  input wire logic probe_i,
  input wire logic req_n_i,
  input wire logic req_oe_i,
  input wire logic init_n_i,
  input wire logic init_oe_i,
  input wire logic block_n_i,
  input wire logic block_oe_i,
  input wire logic [5:0] mon_n_i,
  input wire logic [5:0] mon_oe_i,
  output fsb_arb_pkg::bus_in_s bus_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] pri_left;
  // holds priority until its work ends
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      pri_left <= 4'h0;
    end else if (pri_go_i) begin
      pri_left <= 4'(PRI_LEN);
    end else if (pri_left != 4'h0) begin
      pri_left <= pri_left - 4'h1;
    end
  end
  // terminated lines, high unless pulled low
  always_comb begin
    bus_o.priority_req_n = (pri_left == 4'h0);
    bus_o.bus_init_n = !(init_i || (init_oe_i && !init_n_i));
    bus_o.block_next_req_n = !(stall_i || (block_oe_i && !block_n_i));
    bus_o.system_bus_req0_n = !(strap_id0_i || (req_oe_i && !req_n_i));
    bus_o.probe_request_n = !(probe_i || (mon_oe_i[5] && !mon_n_i[5]));
  end
endmodule : fsb_bus_partner

// [verif/fsb_arbitration_control_bench.sv]
// Self-checking bench of the arbitration and stall control block
module fsb_arbitration_control_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0, rst = 1'b1, drv = 1'b1, obs = 1'b1, pend = 1'b0;
  logic wr = 1'b0, rd = 1'b0, strap = 1'b1, init = 1'b0, stall = 1'b0;
  logic pri = 1'b0, probe = 1'b0, en = 1'b1;
  logic [3:0] addr = 4'h0;
  logic [31:0] wdata = 32'h0, rdata, v;
  logic irq, req_n, req_oe, init_n, init_oe, block_n, block_oe, issue;
  logic [5:0] mon_n, mon_oe;
  logic [2:0] sel;
  logic [1:0] id;
  fsb_arb_pkg::bus_in_s bus;
  int n_fail = 0;
  int n_compared = 0;

  fsb_arbitration_control dut_u (.sys_clk_i(clk), .rst_i(rst),
    .clk_en_i(en), .cfg_drv_en_i(drv), .cfg_obs_en_i(obs), .bus_i(bus),
    .pending_i(pend), .addr_i(addr), .wdata_i(wdata), .wr_i(wr),
    .rd_i(rd), .rdata_o(rdata), .irq_o(irq), .agent_bus_req_n_o(req_n),
    .agent_bus_req_oe_o(req_oe), .bus_init_n_o(init_n),
    .bus_init_oe_o(init_oe), .block_next_req_n_o(block_n),
    .block_next_req_oe_o(block_oe), .brkpt_mon_n_o(mon_n),
    .brkpt_mon_oe_o(mon_oe), .clk_freq_select_o(sel), .issue_o(issue),
    .agent_id_o(id));

  fsb_bus_partner partner_u (.sys_clk_i(clk), .rst_i(rst),
    .strap_id0_i(strap), .init_i(init), .stall_i(stall), .pri_go_i(pri),
    .probe_i(probe), .req_n_i(req_n), .req_oe_i(req_oe),
    .init_n_i(init_n), .init_oe_i(init_oe), .block_n_i(block_n),
    .block_oe_i(block_oe), .mon_n_i(mon_n), .mon_oe_i(mon_oe), .bus_o(bus));

  initial begin
    forever #25 clk = ~clk;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // Checks land 1 ns after an edge, when its updates have settled
  task automatic wait_n(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : wait_n

  task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    #1;
  endtask : wr_reg

  task automatic rd_reg(input logic [3:0] a, output logic [31:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask : rd_reg

  task automatic end_sim;
    if (n_fail == 0 && n_compared > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : end_sim

  initial begin
    repeat (3000) @(posedge clk);
    n_fail++;
    end_sim;
  end

  initial begin
    wait_n(15);
    chk({req_n, init_n, block_n, init_oe, block_oe, irq, issue, sel},
        10'h380);
    @(posedge clk) rst <= 1'b0;
    wait_n(3);
    @(posedge clk) strap <= 1'b0;
    chk(id, fsb_arb_pkg::AGENT_ID_ZERO);
    rd_reg(fsb_arb_pkg::REG_STAT, v);
    chk(v & 32'hF00, 32'h300);
    wr_reg(fsb_arb_pkg::REG_MASK, 32'hF);
    // Field line 4 low and line 5 high: only the ready bit may pull line 4
    wr_reg(fsb_arb_pkg::REG_CTRL, 32'h0025_0508);
    wait_n(2);
    chk(sel, 3'h5);
    chk(mon_n, 6'h2A);
    chk(mon_oe, 6'h1F);
    rd_reg(fsb_arb_pkg::REG_MON, v);
    chk(v, 32'h15);
    rd_reg(fsb_arb_pkg::REG_CTRL, v);
    chk(v, 32'h0025_0508);
    @(posedge clk) pend <= 1'b1;
    wr_reg(fsb_arb_pkg::REG_CTRL, 32'h0015_0509);
    wait_n(4);
    chk({req_n, req_oe, issue}, 3'h3);
    @(posedge clk) stall <= 1'b1;
    wait_n(3);
    chk(issue, 1'b0);
    @(posedge clk) stall <= 1'b0;
    wait_n(3);
    chk({issue, irq}, 2'h3);
    // Clock enable low freezes the block, so the stall acts only after
    @(posedge clk) begin
      en <= 1'b0;
      stall <= 1'b1;
    end
    wait_n(3);
    chk(issue, 1'b1);
    @(posedge clk) en <= 1'b1;
    wait_n(2);
    chk(issue, 1'b0);
    @(posedge clk) stall <= 1'b0;
    rd_reg(fsb_arb_pkg::REG_IRQ, v);
    chk(v, 32'h4);
    wr_reg(fsb_arb_pkg::REG_MASK, 32'h0);
    wait_n(2);
    chk(irq, 1'b0);
    wr_reg(fsb_arb_pkg::REG_MASK, 32'hF);
    wr_reg(fsb_arb_pkg::REG_IRQ, 32'h4);
    wait_n(2);
    chk(irq, 1'b0);
    // Own full flag pulls the shared line, so it stalls itself too
    wr_reg(fsb_arb_pkg::REG_CTRL, 32'h0015_050D);
    wait_n(3);
    chk({block_n, block_oe, issue}, 3'h2);
    wr_reg(fsb_arb_pkg::REG_CTRL, 32'h0015_0509);
    @(posedge clk) pri <= 1'b1;
    @(posedge clk) pri <= 1'b0;
    wait_n(2);
    chk(issue, 1'b0);
    wait_n(8);
    chk(issue, 1'b1);
    wr_reg(fsb_arb_pkg::REG_CTRL, 32'h0015_0519);
    @(posedge clk) pri <= 1'b1;
    @(posedge clk) pri <= 1'b0;
    wait_n(2);
    chk(issue, 1'b1);
    rd_reg(fsb_arb_pkg::REG_IRQ, v);
    chk(v, 32'h6);
    wr_reg(fsb_arb_pkg::REG_IRQ, 32'hF);
    @(posedge clk) probe <= 1'b1;
    @(posedge clk) probe <= 1'b0;
    rd_reg(fsb_arb_pkg::REG_IRQ, v);
    chk(v, 32'h8);
    @(posedge clk) init <= 1'b1;
    wait_n(3);
    chk(req_n, 1'b1);
    @(posedge clk) init <= 1'b0;
    wait_n(4);
    chk(req_n, 1'b0);
    rd_reg(fsb_arb_pkg::REG_IRQ, v);
    chk(v[0], 1'b1);
    wr_reg(fsb_arb_pkg::REG_CTRL, 32'h0015_050B);
    wait_n(2);
    chk({init_n, init_oe}, 2'h1);
    wr_reg(fsb_arb_pkg::REG_CTRL, 32'h0015_0509);
    rd_reg(4'hF, v);
    chk(v, 32'h0);
    @(posedge clk) begin
      rst <= 1'b1;
      drv <= 1'b0;
      obs <= 1'b0;
    end
    wait_n(16);
    @(posedge clk) rst <= 1'b0;
    wait_n(3);
    // Straps change after the latch and must be ignored
    @(posedge clk) begin
      drv <= 1'b1;
      obs <= 1'b1;
    end
    chk(id, 2'h3);
    wr_reg(fsb_arb_pkg::REG_CTRL, 32'h0000_0003);
    wait_n(4);
    chk({init_n, req_n}, 2'h2);
    // Observation off: outside init must leave the request alone
    @(posedge clk) init <= 1'b1;
    wait_n(3);
    chk(req_n, 1'b0);
    end_sim;
  end
endmodule : fsb_arbitration_control_bench
